/* File: hdl/dacdc_cfg.svh */
`ifndef DACDC_CFG_SVH
`define DACDC_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define DACDC_IDX_CONTROL_A 5'h00
`define DACDC_IDX_CONTROL_B 5'h01
`define DACDC_IDX_CONTROL_C 5'h02
`define DACDC_IDX_TRIG_SEL 5'h03
`define DACDC_IDX_EMPTY_FLAGS 5'h05
`define DACDC_IDX_CH0_GAIN 5'h08
`define DACDC_IDX_CH0_OFFSET 5'h09
`define DACDC_IDX_CH1_GAIN 5'h0a
`define DACDC_IDX_CH1_OFFSET 5'h0b
`define DACDC_IDX_CH0_LOW 5'h18
`define DACDC_IDX_CH0_HIGH 5'h19
`define DACDC_IDX_CH1_LOW 5'h1a
`define DACDC_IDX_CH1_HIGH 5'h1b

// ==========================================================
// writable bit masks, reserved bits read as zero
`define DACDC_MASK_CONTROL_A 8'h1f
`define DACDC_MASK_CONTROL_B 8'h63
`define DACDC_MASK_CONTROL_C 8'h19
`define DACDC_MASK_TRIG_SEL 8'h0f
`define DACDC_MASK_EMPTY_FLAGS 8'h03

// ==========================================================
// field positions and reset values
`define DACDC_BIT_LEFT_ALIGN 0
`define DACDC_RST_BYTE 8'h00
`define DACDC_RST_VALUE 12'h000
`define DACDC_RST_WORD 32'h0000_0000
`define DACDC_NIBBLE_ZERO 4'h0

`endif

/* File: hdl/dacdc_pkg.sv */
package dacdc_pkg;
  // ==========================================================
  // types
  typedef logic [4:0] dacdc_idx_t;
  typedef logic [7:0] dacdc_byte_t;
  typedef logic [11:0] dacdc_value_t;

  typedef enum logic [3:0] {
    DACDC_ST_IDLE = 4'b0001,
    DACDC_ST_WRITE = 4'b0010,
    DACDC_ST_RDWAIT = 4'b0100,
    DACDC_ST_RDDATA = 4'b1000
  } dacdc_bus_state_e;
endpackage

/* File: hdl/dacdc_ahb_port.sv */
`timescale 1ns/1ps
`include "dacdc_cfg.svh"

module dacdc_ahb_port #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output dacdc_pkg::dacdc_idx_t acc_idx,
  output logic wr_stb,
  output logic rd_stb
);
  import dacdc_pkg::*;

  if (ADDR_W < 8) begin : g_bad_width
    $error("dacdc_ahb_port: ADDR_W must be at least 8");
  end

  dacdc_bus_state_e state, next_state;
  dacdc_idx_t next_acc_idx;
  logic acc_mapped, next_acc_mapped;
  logic take;

  // ==========================================================
  // address phase capture
  assign take = hsel && hready && htrans[1];

  always_comb begin
    next_state = state;
    next_acc_idx = acc_idx;
    next_acc_mapped = acc_mapped;
    case (state)
      DACDC_ST_RDWAIT: begin
        next_state = DACDC_ST_RDDATA;
      end
      DACDC_ST_IDLE, DACDC_ST_WRITE, DACDC_ST_RDDATA: begin
        if (take) begin
          next_state = hwrite ? DACDC_ST_WRITE : DACDC_ST_RDWAIT;
          next_acc_idx = haddr[6:2];
          // anything above the 32-word window is unmapped
          next_acc_mapped = (haddr[ADDR_W-1:7] == '0);
        end else begin
          next_state = DACDC_ST_IDLE;
        end
      end
      default: begin
        next_state = DACDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= DACDC_ST_IDLE;
      acc_idx <= '0;
      acc_mapped <= 1'b0;
    end else begin
      state <= next_state;
      acc_idx <= next_acc_idx;
      acc_mapped <= next_acc_mapped;
    end
  end

  // a read waits one cycle so that read data come from a register
  // and never miss a write finishing just before it
  assign hreadyout = (state != DACDC_ST_RDWAIT);
  assign hresp = 1'b0;
  assign wr_stb = (state == DACDC_ST_WRITE) && acc_mapped;
  assign rd_stb = (state == DACDC_ST_RDWAIT) && acc_mapped;

  chk_read_stall: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read data phase did not stall for exactly one cycle");

endmodule // dacdc_ahb_port

/* File: hdl/dacdc_chan.sv */
`timescale 1ns/1ps
`include "dacdc_cfg.svh"

module dacdc_chan (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic left_align,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire dacdc_pkg::dacdc_byte_t wdata,
  output dacdc_pkg::dacdc_value_t value,
  output logic commit
);
  import dacdc_pkg::*;

  dacdc_byte_t stage, next_stage;
  dacdc_value_t next_value;
  logic next_commit;

  // ==========================================================
  // staging latch and atomic commit
  always_comb begin
    next_stage = stage;
    next_value = value;
    next_commit = 1'b0;
    if (wr_low) begin
      // reserved nibble is dropped so it never reaches the value
      next_stage = left_align ? {wdata[7:4], `DACDC_NIBBLE_ZERO} : wdata;
    end
    if (wr_high) begin
      next_commit = 1'b1;
      if (left_align) begin
        next_value = {wdata, stage[7:4]};
      end else begin
        next_value = {wdata[3:0], stage};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage <= `DACDC_RST_BYTE;
      value <= `DACDC_RST_VALUE;
      commit <= 1'b0;
    end else begin
      stage <= next_stage;
      value <= next_value;
      commit <= next_commit;
    end
  end

  chk_low_no_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_low && !wr_high) |=> $stable(value))
    else $error("low byte write changed the channel value");

  chk_right_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_high && !left_align) |=> value == {$past(wdata[3:0]), $past(stage)})
    else $error("right-aligned commit assembled the wrong value");

  chk_left_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_high && left_align) |=> value == {$past(wdata), $past(stage[7:4])})
    else $error("left-aligned commit assembled the wrong value");

endmodule // dacdc_chan

/* File: hdl/dacdc_regs.sv */
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "dacdc_cfg.svh"

module dacdc_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output dacdc_pkg::dacdc_value_t ch0_conversion_value,
  output dacdc_pkg::dacdc_value_t ch1_conversion_value,
  output logic [1:0] value_commit,
  output dacdc_pkg::dacdc_byte_t ch0_gain_trim,
  output dacdc_pkg::dacdc_byte_t ch0_offset_trim,
  output dacdc_pkg::dacdc_byte_t ch1_gain_trim,
  output dacdc_pkg::dacdc_byte_t ch1_offset_trim,
  output dacdc_pkg::dacdc_byte_t dac_control_a,
  output dacdc_pkg::dacdc_byte_t dac_control_b,
  output dacdc_pkg::dacdc_byte_t dac_control_c,
  output dacdc_pkg::dacdc_byte_t trigger_source_select,
  output dacdc_pkg::dacdc_byte_t channel_empty_flags,
  output logic left_align_select
);
  import dacdc_pkg::*;

  if (ADDR_W < 8) begin : g_bad_width
    $error("dacdc_regs: ADDR_W must be at least 8");
  end

  // ==========================================================
  // read views of a channel value
  function automatic dacdc_byte_t low_view(input dacdc_value_t v, input logic left);
    low_view = left ? {v[3:0], `DACDC_NIBBLE_ZERO} : v[7:0];
  endfunction

  function automatic dacdc_byte_t high_view(input dacdc_value_t v, input logic left);
    high_view = left ? v[11:4] : {`DACDC_NIBBLE_ZERO, v[11:8]};
  endfunction

  // ==========================================================
  // bus front end
  dacdc_idx_t acc_idx;
  logic wr_stb;
  logic rd_stb;
  dacdc_byte_t wbyte;

  // only byte lane 0 carries register data; upper lanes are ignored
  assign wbyte = hwdata[7:0];

  dacdc_ahb_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .acc_idx(acc_idx),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  // ==========================================================
  // write decode
  logic wr_ch0_low, wr_ch0_high, wr_ch1_low, wr_ch1_high;

  assign wr_ch0_low = wr_stb && (acc_idx == `DACDC_IDX_CH0_LOW);
  assign wr_ch0_high = wr_stb && (acc_idx == `DACDC_IDX_CH0_HIGH);
  assign wr_ch1_low = wr_stb && (acc_idx == `DACDC_IDX_CH1_LOW);
  assign wr_ch1_high = wr_stb && (acc_idx == `DACDC_IDX_CH1_HIGH);

  // layout follows the align bit of the third control register
  assign left_align_select = dac_control_c[`DACDC_BIT_LEFT_ALIGN];

  // ==========================================================
  // channel data pairs
  dacdc_chan u_ch0 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .left_align(left_align_select),
    .wr_low(wr_ch0_low),
    .wr_high(wr_ch0_high),
    .wdata(wbyte),
    .value(ch0_conversion_value),
    .commit(value_commit[0])
  );

  dacdc_chan u_ch1 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .left_align(left_align_select),
    .wr_low(wr_ch1_low),
    .wr_high(wr_ch1_high),
    .wdata(wbyte),
    .value(ch1_conversion_value),
    .commit(value_commit[1])
  );

  // ==========================================================
  // control and calibration registers
  dacdc_byte_t next_control_a, next_control_b, next_control_c;
  dacdc_byte_t next_trig_sel, next_empty_flags;
  dacdc_byte_t next_ch0_gain, next_ch0_offset, next_ch1_gain, next_ch1_offset;

  always_comb begin
    next_control_a = dac_control_a;
    next_control_b = dac_control_b;
    next_control_c = dac_control_c;
    next_trig_sel = trigger_source_select;
    next_empty_flags = channel_empty_flags;
    next_ch0_gain = ch0_gain_trim;
    next_ch0_offset = ch0_offset_trim;
    next_ch1_gain = ch1_gain_trim;
    next_ch1_offset = ch1_offset_trim;
    if (wr_stb) begin
      // masking keeps reserved bits at zero even if software breaks the habit
      case (acc_idx)
        `DACDC_IDX_CONTROL_A: next_control_a = wbyte & `DACDC_MASK_CONTROL_A;
        `DACDC_IDX_CONTROL_B: next_control_b = wbyte & `DACDC_MASK_CONTROL_B;
        `DACDC_IDX_CONTROL_C: next_control_c = wbyte & `DACDC_MASK_CONTROL_C;
        `DACDC_IDX_TRIG_SEL: next_trig_sel = wbyte & `DACDC_MASK_TRIG_SEL;
        `DACDC_IDX_EMPTY_FLAGS: next_empty_flags = wbyte & `DACDC_MASK_EMPTY_FLAGS;
        `DACDC_IDX_CH0_GAIN: next_ch0_gain = wbyte;
        `DACDC_IDX_CH0_OFFSET: next_ch0_offset = wbyte;
        `DACDC_IDX_CH1_GAIN: next_ch1_gain = wbyte;
        `DACDC_IDX_CH1_OFFSET: next_ch1_offset = wbyte;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dac_control_a <= `DACDC_RST_BYTE;
      dac_control_b <= `DACDC_RST_BYTE;
      dac_control_c <= `DACDC_RST_BYTE;
      trigger_source_select <= `DACDC_RST_BYTE;
      channel_empty_flags <= `DACDC_RST_BYTE;
      ch0_gain_trim <= `DACDC_RST_BYTE;
      ch0_offset_trim <= `DACDC_RST_BYTE;
      ch1_gain_trim <= `DACDC_RST_BYTE;
      ch1_offset_trim <= `DACDC_RST_BYTE;
    end else begin
      dac_control_a <= next_control_a;
      dac_control_b <= next_control_b;
      dac_control_c <= next_control_c;
      trigger_source_select <= next_trig_sel;
      channel_empty_flags <= next_empty_flags;
      ch0_gain_trim <= next_ch0_gain;
      ch0_offset_trim <= next_ch0_offset;
      ch1_gain_trim <= next_ch1_gain;
      ch1_offset_trim <= next_ch1_offset;
    end
  end

  // ==========================================================
  // read path
  dacdc_byte_t rd_byte;
  logic [31:0] next_hrdata;

  always_comb begin
    rd_byte = `DACDC_RST_BYTE;
    case (acc_idx)
      `DACDC_IDX_CONTROL_A: rd_byte = dac_control_a;
      `DACDC_IDX_CONTROL_B: rd_byte = dac_control_b;
      `DACDC_IDX_CONTROL_C: rd_byte = dac_control_c;
      `DACDC_IDX_TRIG_SEL: rd_byte = trigger_source_select;
      `DACDC_IDX_EMPTY_FLAGS: rd_byte = channel_empty_flags;
      `DACDC_IDX_CH0_GAIN: rd_byte = ch0_gain_trim;
      `DACDC_IDX_CH0_OFFSET: rd_byte = ch0_offset_trim;
      `DACDC_IDX_CH1_GAIN: rd_byte = ch1_gain_trim;
      `DACDC_IDX_CH1_OFFSET: rd_byte = ch1_offset_trim;
      // reads show the committed value; a staged low byte stays hidden
      `DACDC_IDX_CH0_LOW: rd_byte = low_view(ch0_conversion_value, left_align_select);
      `DACDC_IDX_CH0_HIGH: rd_byte = high_view(ch0_conversion_value, left_align_select);
      `DACDC_IDX_CH1_LOW: rd_byte = low_view(ch1_conversion_value, left_align_select);
      `DACDC_IDX_CH1_HIGH: rd_byte = high_view(ch1_conversion_value, left_align_select);
      default: rd_byte = `DACDC_RST_BYTE;
    endcase
  end

  always_comb begin
    next_hrdata = hrdata;
    if (rd_stb) begin
      next_hrdata = {24'h00_0000, rd_byte};
    end else if (hreadyout) begin
      next_hrdata = `DACDC_RST_WORD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hrdata <= `DACDC_RST_WORD;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // ==========================================================
  // checks
  chk_gain_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH0_GAIN) |=> ch0_gain_trim == $past(wbyte))
    else $error("channel 0 gain trim did not take the written byte");

  chk_ch1_gain_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH1_GAIN) |=> ch1_gain_trim == $past(wbyte))
    else $error("channel 1 gain trim did not take the written byte");

  chk_offset_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH1_OFFSET) |=> ch1_offset_trim == $past(wbyte))
    else $error("channel 1 offset trim did not take the written byte");

  chk_ch0_offset_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH0_OFFSET) |=> ch0_offset_trim == $past(wbyte))
    else $error("channel 0 offset trim did not take the written byte");

  chk_trim_isolation: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH1_GAIN) |=> $stable(ch0_gain_trim))
    else $error("channel 1 gain write disturbed channel 0 gain trim");

  chk_high_right_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rd_stb && acc_idx == `DACDC_IDX_CH0_HIGH && !left_align_select)
      |=> hrdata == {24'h00_0000, 4'h0, ch0_conversion_value[11:8]})
    else $error("right-aligned high byte read is wrong");

  chk_low_right_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rd_stb && acc_idx == `DACDC_IDX_CH0_LOW && !left_align_select)
      |=> hrdata == {24'h00_0000, ch0_conversion_value[7:0]})
    else $error("right-aligned low byte read is wrong");

  chk_high_left_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rd_stb && acc_idx == `DACDC_IDX_CH1_HIGH && left_align_select)
      |=> hrdata == {24'h00_0000, ch1_conversion_value[11:4]})
    else $error("left-aligned high byte read is wrong");

  chk_low_left_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rd_stb && acc_idx == `DACDC_IDX_CH1_LOW && left_align_select)
      |=> hrdata == {24'h00_0000, ch1_conversion_value[3:0], 4'h0})
    else $error("left-aligned low byte read is wrong");

  chk_ch1_pair_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH1_HIGH)
      |=> value_commit == 2'b10 && $stable(ch0_conversion_value))
    else $error("channel 1 high write did not commit channel 1 alone");

  chk_ch0_pair_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH0_HIGH) |=> value_commit == 2'b01)
    else $error("channel 0 high write did not commit channel 0 alone");

  chk_ch0_pair_isolation: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH0_HIGH) |=> $stable(ch1_conversion_value))
    else $error("channel 0 high write disturbed channel 1 value");

  chk_staged_hidden: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CH1_LOW) |=> $stable(ch1_conversion_value))
    else $error("channel 1 low write changed the committed value");

  chk_align_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_stb && acc_idx == `DACDC_IDX_CONTROL_C) |=> left_align_select == $past(wbyte[0]))
    else $error("align select did not follow the control write");

  // ==========================================================
  // reset checks, then the reserved-bit check
  // no disable iff on the three reset checks: they must see the edge that applies the reset
  chk_data_reset: assert property (@(posedge clk_sys)
    !rst_b |=> ch0_conversion_value == `DACDC_RST_VALUE
      && ch1_conversion_value == `DACDC_RST_VALUE)
    else $error("channel values did not clear on reset");

  chk_trim_reset: assert property (@(posedge clk_sys)
    !rst_b |=> ch0_gain_trim == `DACDC_RST_BYTE && ch1_gain_trim == `DACDC_RST_BYTE)
    else $error("gain trims did not clear on reset");

  chk_offset_reset: assert property (@(posedge clk_sys)
    !rst_b |=> ch0_offset_trim == `DACDC_RST_BYTE && ch1_offset_trim == `DACDC_RST_BYTE)
    else $error("offset trims did not clear on reset");

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (dac_control_c & ~`DACDC_MASK_CONTROL_C) == 8'h00)
    else $error("reserved control bits became set");

endmodule // dacdc_regs

/* File: tb/dacdc_regs_bench.sv */
`timescale 1ns/1ps
`include "dacdc_cfg.svh"

module dacdc_regs_bench;
  import dacdc_pkg::*;
  // ==========================================================
  // signals
  logic clk_sys;
  logic rst_b;
  logic hsel;
  logic hwrite;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd_cap;
  logic hreadyout;
  logic hresp;
  dacdc_value_t v0;
  dacdc_value_t v1;
  logic [1:0] commit;
  dacdc_byte_t g0, o0, g1, o1;
  dacdc_byte_t ca, cb, cc, ts, ef;
  logic align;
  int num_errors;
  int checks_done;
  dacdc_idx_t rz [8] = '{`DACDC_IDX_CH0_GAIN, `DACDC_IDX_CH0_OFFSET, `DACDC_IDX_CH1_GAIN,
    `DACDC_IDX_CH1_OFFSET, `DACDC_IDX_CH0_LOW, `DACDC_IDX_CH0_HIGH, `DACDC_IDX_CH1_LOW,
    `DACDC_IDX_CH1_HIGH};
  dacdc_idx_t cx [5] = '{`DACDC_IDX_CONTROL_A, `DACDC_IDX_CONTROL_B, `DACDC_IDX_CONTROL_C,
    `DACDC_IDX_TRIG_SEL, `DACDC_IDX_EMPTY_FLAGS};
  dacdc_byte_t cm [5] = '{8'h1f, 8'h63, 8'h18, 8'h0f, 8'h03};

  // ==========================================================
  // design
  dacdc_regs u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ch0_conversion_value(v0), .ch1_conversion_value(v1), .value_commit(commit),
    .ch0_gain_trim(g0), .ch0_offset_trim(o0), .ch1_gain_trim(g1), .ch1_offset_trim(o1),
    .dac_control_a(ca), .dac_control_b(cb), .dac_control_c(cc), .trigger_source_select(ts),
    .channel_empty_flags(ef), .left_align_select(align)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // bus tasks
  function automatic logic [11:0] ad(input dacdc_idx_t i);
    return {5'h00, i, 2'b00};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hready is sampled at the rising edge, and read data is taken at that same edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    rd_cap = hrdata;
  endtask

  task automatic bus_xfer(input logic [11:0] a, input logic wr, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_ready();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus_xfer(a, 1'b0, 8'h00);
    check(rd_cap, e);
  endtask

  // write a data byte, then look at the commit pulse and both values
  task automatic wr_val(input dacdc_idx_t i, input dacdc_byte_t d, input logic [1:0] ec,
                        input dacdc_value_t e0, input dacdc_value_t e1);
    bus_xfer(ad(i), 1'b1, d);
    @(negedge clk_sys);
    check({30'h0, commit}, {30'h0, ec});
    check({20'h0, v0}, {20'h0, e0});
    check({20'h0, v1}, {20'h0, e1});
    @(posedge clk_sys);
  endtask

  task automatic rst_zero();
    for (int k = 0; k < 8; k++) begin
      rd_chk(ad(rz[k]), 32'h0);
    end
    check({g0, o0, g1, o1}, 32'h0);
    check({8'h0, v0, v1}, 32'h0);
    check({ca, cb, cc, ts}, 32'h0);
    check({24'h0, ef}, 32'h0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    num_errors = 0;
    checks_done = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rst_zero();
    bus_xfer(ad(`DACDC_IDX_CH0_GAIN), 1'b1, 8'h81);
    bus_xfer(ad(`DACDC_IDX_CH0_OFFSET), 1'b1, 8'h7e);
    bus_xfer(ad(`DACDC_IDX_CH1_GAIN), 1'b1, 8'hc3);
    bus_xfer(ad(`DACDC_IDX_CH1_OFFSET), 1'b1, 8'h3c);
    rd_chk(ad(`DACDC_IDX_CH0_GAIN), 32'h81);
    rd_chk(ad(`DACDC_IDX_CH0_OFFSET), 32'h7e);
    rd_chk(ad(`DACDC_IDX_CH1_GAIN), 32'hc3);
    rd_chk(ad(`DACDC_IDX_CH1_OFFSET), 32'h3c);
    check({g0, o0, g1, o1}, 32'h817ec33c);
    check({31'h0, hresp}, 32'h0);
    // control bytes keep their writable bits; reserved bits are written as zero
    for (int k = 0; k < 5; k++) begin
      bus_xfer(ad(cx[k]), 1'b1, cm[k]);
    end
    for (int k = 0; k < 5; k++) begin
      rd_chk(ad(cx[k]), {24'h0, cm[k]});
    end
    check({ca, cb, cc, ts}, 32'h1f63180f);
    check({24'h0, ef}, 32'h03);
    check({31'h0, align}, 32'h0);
    // right layout; reserved high nibble written as zero
    wr_val(`DACDC_IDX_CH0_LOW, 8'hab, 2'b00, 12'h000, 12'h000);
    rd_chk(ad(`DACDC_IDX_CH0_LOW), 32'h0);
    wr_val(`DACDC_IDX_CH0_HIGH, 8'h05, 2'b01, 12'h5ab, 12'h000);
    rd_chk(ad(`DACDC_IDX_CH0_LOW), 32'hab);
    rd_chk(ad(`DACDC_IDX_CH0_HIGH), 32'h05);
    wr_val(`DACDC_IDX_CH1_LOW, 8'h34, 2'b00, 12'h5ab, 12'h000);
    wr_val(`DACDC_IDX_CH1_HIGH, 8'h0c, 2'b10, 12'h5ab, 12'hc34);
    rd_chk(ad(`DACDC_IDX_CH1_LOW), 32'h34);
    rd_chk(ad(`DACDC_IDX_CH1_HIGH), 32'h0c);
    // left layout applies to both channels at once
    bus_xfer(ad(`DACDC_IDX_CONTROL_C), 1'b1, 8'h01);
    @(negedge clk_sys);
    check({31'h0, align}, 32'h1);
    @(posedge clk_sys);
    rd_chk(ad(`DACDC_IDX_CH0_HIGH), 32'h5a);
    rd_chk(ad(`DACDC_IDX_CH0_LOW), 32'hb0);
    rd_chk(ad(`DACDC_IDX_CH1_HIGH), 32'hc3);
    rd_chk(ad(`DACDC_IDX_CH1_LOW), 32'h40);
    wr_val(`DACDC_IDX_CH0_LOW, 8'h70, 2'b00, 12'h5ab, 12'hc34);
    wr_val(`DACDC_IDX_CH0_HIGH, 8'h9e, 2'b01, 12'h9e7, 12'hc34);
    rd_chk(ad(`DACDC_IDX_CH0_LOW), 32'h70);
    rd_chk(ad(`DACDC_IDX_CH0_HIGH), 32'h9e);
    // 8-bit mode: latch cleared once, then high bytes alone
    wr_val(`DACDC_IDX_CH1_LOW, 8'h00, 2'b00, 12'h9e7, 12'hc34);
    wr_val(`DACDC_IDX_CH1_HIGH, 8'h42, 2'b10, 12'h9e7, 12'h420);
    wr_val(`DACDC_IDX_CH1_HIGH, 8'h43, 2'b10, 12'h9e7, 12'h430);
    bus_xfer(ad(`DACDC_IDX_CONTROL_C), 1'b1, 8'h00);
    rd_chk(ad(`DACDC_IDX_CH1_HIGH), 32'h04);
    rd_chk(ad(`DACDC_IDX_CH1_LOW), 32'h30);
    // unmapped places must neither answer nor alias onto the trims
    bus_xfer(12'h040, 1'b1, 8'hff);
    bus_xfer(12'h820, 1'b1, 8'hff);
    rd_chk(12'h040, 32'h0);
    rd_chk(ad(`DACDC_IDX_CH0_GAIN), 32'h81);
    check({g0, o0, g1, o1}, 32'h817ec33c);
    // second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rst_zero();
    tally_and_finish();
  end
endmodule // dacdc_regs_bench
